// ### hdl/compact_load_store_defines.svh
// constants for the compressed load/store decoder
`ifndef COMPACT_LOAD_STORE_DEFINES_SVH
`define COMPACT_LOAD_STORE_DEFINES_SVH

// --------------------------------------------------------------
// format opcodes and their positions
// --------------------------------------------------------------
`define CLS_PCREL_OP_HI 15
`define CLS_PCREL_OP_LO 11
`define CLS_PCREL_OP 5'h09
`define CLS_REGOFF_OP_HI 15
`define CLS_REGOFF_OP_LO 12
`define CLS_REGOFF_OP 4'h5
`define CLS_REGOFF_SEL_BIT 9
`define CLS_IMMOFF_OP_HI 15
`define CLS_IMMOFF_OP_LO 13
`define CLS_IMMOFF_OP 3'h3

// --------------------------------------------------------------
// flag and field positions
// --------------------------------------------------------------
`define CLS_F7_LOAD_BIT 11
`define CLS_F7_BYTE_BIT 10
`define CLS_F8_LOAD_BIT 10
`define CLS_F8_BYTE_BIT 11
`define CLS_F9_BYTE_BIT 12
`define CLS_F9_LOAD_BIT 11
`define CLS_PCREL_RD_HI 10
`define CLS_PCREL_RD_LO 8
`define CLS_WORD8_HI 7
`define CLS_WORD8_LO 0
`define CLS_IMM5_HI 10
`define CLS_IMM5_LO 6
`define CLS_OFFREG_HI 8
`define CLS_OFFREG_LO 6
`define CLS_BASEREG_HI 5
`define CLS_BASEREG_LO 3
`define CLS_RD_HI 2
`define CLS_RD_LO 0

// --------------------------------------------------------------
// address arithmetic and reset values
// --------------------------------------------------------------
`define CLS_PC_ADJUST 32'h0000_0004
`define CLS_WORD_SHIFT 2
`define CLS_RESET_WORD 32'h0000_0000
`define CLS_RESET_REG 3'h0

`endif

// ### hdl/compact_load_store_pkg.sv
// types shared by the compressed load/store decoder
package compact_load_store_pkg;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } access_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ACCESS = 2'h2
  } state_t;

endpackage

// ### hdl/compact_load_store_decode.sv
// decode and address generation for compressed load/store formats
// Functional notes
// - pc-relative load adds up to 255 words to base, loads word
// - relative base is instruction address plus four, bit 1 cleared
// - eight-bit word offset shifted left two into ten-bit byte offset
// - register-offset address is base register plus offset register
// - register-offset: load flag picks load, byte flag picks byte
// - byte stores write only the low byte of the source
// - halfword format, flags zero: store low sixteen source bits
// - halfword format, byte flag only: load halfword, zero upper bits
// - halfword format, load flag only: load byte, sign extend bit seven
// - halfword format, both flags: load halfword, sign extend bit 15
// - immediate format adds five-bit field to base register
// - immediate word access shifts the field left by two
// - immediate format flags pick direction and size; word loads full
// - each access behaves and times like its full-width equivalent
`include "compact_load_store_defines.svh"

module compact_load_store_decode #(
  parameter int DATA_W = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [31:0] instr_addr_in,
  output logic instr_ready_out,
  output logic [2:0] base_sel_out,
  output logic [2:0] offset_sel_out,
  output logic [2:0] src_sel_out,
  input wire logic [31:0] base_value_in,
  input wire logic [31:0] offset_value_in,
  input wire logic [31:0] src_value_in,
  output logic mem_req_out,
  output logic mem_write_out,
  output compact_load_store_pkg::access_size_t mem_size_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  input wire logic mem_done_in,
  input wire logic [31:0] mem_rdata_in,
  output logic rd_we_out,
  output logic [2:0] rd_sel_out,
  output logic [31:0] rd_data_out,
  output logic illegal_out
);

  // --------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("compact_load_store_decode supports only DATA_W of 32");
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] extend_load(
    input compact_load_store_pkg::access_size_t size,
    input logic signed_load,
    input logic [31:0] raw
  );
    logic [31:0] value;
    value = raw;
    unique case (size)
      compact_load_store_pkg::SIZE_BYTE: begin
        value = signed_load ? {{24{raw[7]}}, raw[7:0]}
                            : {24'h000000, raw[7:0]};
      end
      compact_load_store_pkg::SIZE_HALF: begin
        value = signed_load ? {{16{raw[15]}}, raw[15:0]}
                            : {16'h0000, raw[15:0]};
      end
      compact_load_store_pkg::SIZE_WORD: begin
        value = raw;
      end
      default: begin
        value = raw;
      end
    endcase
    return value;
  endfunction

  function automatic logic [31:0] store_data(
    input compact_load_store_pkg::access_size_t size,
    input logic [31:0] src
  );
    logic [31:0] value;
    value = src;
    unique case (size)
      compact_load_store_pkg::SIZE_BYTE: value = {24'h000000, src[7:0]};
      compact_load_store_pkg::SIZE_HALF: value = {16'h0000, src[15:0]};
      compact_load_store_pkg::SIZE_WORD: value = src;
      default: value = src;
    endcase
    return value;
  endfunction

  // --------------------------------------------------------------
  // format detection and field extraction
  // --------------------------------------------------------------
  logic is_pcrel;
  logic is_regoff;
  logic is_signext;
  logic is_immoff;
  logic dec_load;
  logic dec_signed;
  logic dec_legal;
  compact_load_store_pkg::access_size_t dec_size;
  logic [31:0] pc_base;
  logic [9:0] pcrel_offset;
  logic [6:0] imm_offset;
  logic [31:0] dec_addr;
  logic [2:0] dec_rd;

  always_comb begin
    is_pcrel = instr_in[`CLS_PCREL_OP_HI:`CLS_PCREL_OP_LO] == `CLS_PCREL_OP;
    is_regoff = instr_in[`CLS_REGOFF_OP_HI:`CLS_REGOFF_OP_LO]
                == `CLS_REGOFF_OP && !instr_in[`CLS_REGOFF_SEL_BIT];
    is_signext = instr_in[`CLS_REGOFF_OP_HI:`CLS_REGOFF_OP_LO]
                 == `CLS_REGOFF_OP && instr_in[`CLS_REGOFF_SEL_BIT];
    is_immoff = instr_in[`CLS_IMMOFF_OP_HI:`CLS_IMMOFF_OP_LO]
                == `CLS_IMMOFF_OP;
    dec_legal = is_pcrel || is_regoff || is_signext || is_immoff;
    base_sel_out = instr_in[`CLS_BASEREG_HI:`CLS_BASEREG_LO];
    offset_sel_out = instr_in[`CLS_OFFREG_HI:`CLS_OFFREG_LO];
    src_sel_out = instr_in[`CLS_RD_HI:`CLS_RD_LO];
    dec_rd = instr_in[`CLS_RD_HI:`CLS_RD_LO];
    // relative base: address plus four, bit 1 forced low
    pc_base = instr_addr_in + `CLS_PC_ADJUST;
    pc_base[1] = 1'b0;
    pcrel_offset = {instr_in[`CLS_WORD8_HI:`CLS_WORD8_LO], 2'h0};
    if (instr_in[`CLS_F9_BYTE_BIT]) begin
      imm_offset = {2'h0, instr_in[`CLS_IMM5_HI:`CLS_IMM5_LO]};
    end else begin
      imm_offset = 7'({instr_in[`CLS_IMM5_HI:`CLS_IMM5_LO], 2'h0});
    end
    dec_load = 1'b0;
    dec_signed = 1'b0;
    dec_size = compact_load_store_pkg::SIZE_WORD;
    dec_addr = `CLS_RESET_WORD;
    if (is_pcrel) begin
      dec_load = 1'b1;
      dec_addr = pc_base + {22'h000000, pcrel_offset};
      dec_rd = instr_in[`CLS_PCREL_RD_HI:`CLS_PCREL_RD_LO];
    end else if (is_regoff) begin
      dec_load = instr_in[`CLS_F7_LOAD_BIT];
      dec_size = instr_in[`CLS_F7_BYTE_BIT]
                 ? compact_load_store_pkg::SIZE_BYTE
                 : compact_load_store_pkg::SIZE_WORD;
      dec_addr = base_value_in + offset_value_in;
    end else if (is_signext) begin
      dec_addr = base_value_in + offset_value_in;
      unique case ({instr_in[`CLS_F8_LOAD_BIT], instr_in[`CLS_F8_BYTE_BIT]})
        2'h0: begin
          dec_size = compact_load_store_pkg::SIZE_HALF;
        end
        2'h1: begin
          dec_load = 1'b1;
          dec_size = compact_load_store_pkg::SIZE_HALF;
        end
        2'h2: begin
          dec_load = 1'b1;
          dec_signed = 1'b1;
          dec_size = compact_load_store_pkg::SIZE_BYTE;
        end
        2'h3: begin
          dec_load = 1'b1;
          dec_signed = 1'b1;
          dec_size = compact_load_store_pkg::SIZE_HALF;
        end
      endcase
    end else if (is_immoff) begin
      dec_load = instr_in[`CLS_F9_LOAD_BIT];
      dec_size = instr_in[`CLS_F9_BYTE_BIT]
                 ? compact_load_store_pkg::SIZE_BYTE
                 : compact_load_store_pkg::SIZE_WORD;
      dec_addr = base_value_in + {25'h0000000, imm_offset};
    end
  end

  // --------------------------------------------------------------
  // sequencing state
  // --------------------------------------------------------------
  compact_load_store_pkg::state_t state;
  compact_load_store_pkg::state_t next_state;
  logic mem_req;
  logic next_mem_req;
  logic mem_write;
  logic next_mem_write;
  compact_load_store_pkg::access_size_t mem_size;
  compact_load_store_pkg::access_size_t next_mem_size;
  logic [31:0] mem_addr;
  logic [31:0] next_mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] next_mem_wdata;
  logic load_signed;
  logic next_load_signed;
  logic [2:0] rd_sel;
  logic [2:0] next_rd_sel;
  logic rd_we;
  logic next_rd_we;
  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  logic illegal;
  logic next_illegal;

  always_comb begin
    next_state = state;
    next_mem_req = mem_req;
    next_mem_write = mem_write;
    next_mem_size = mem_size;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_load_signed = load_signed;
    next_rd_sel = rd_sel;
    next_rd_we = 1'b0;
    next_rd_data = rd_data;
    next_illegal = 1'b0;
    unique case (state)
      compact_load_store_pkg::ST_IDLE: begin
        if (instr_valid_in && dec_legal) begin
          // one access, as its full-width counterpart would issue
          next_state = compact_load_store_pkg::ST_ACCESS;
          next_mem_req = 1'b1;
          next_mem_write = !dec_load;
          next_mem_size = dec_size;
          next_mem_addr = dec_addr;
          next_mem_wdata = dec_load ? `CLS_RESET_WORD
                                    : store_data(dec_size, src_value_in);
          next_load_signed = dec_signed;
          next_rd_sel = dec_rd;
        end else if (instr_valid_in) begin
          next_illegal = 1'b1;
        end
      end
      compact_load_store_pkg::ST_ACCESS: begin
        if (mem_done_in) begin
          next_state = compact_load_store_pkg::ST_IDLE;
          next_mem_req = 1'b0;
          if (!mem_write) begin
            next_rd_we = 1'b1;
            next_rd_data = extend_load(mem_size, load_signed, mem_rdata_in);
          end
        end
      end
      default: begin
        next_state = compact_load_store_pkg::ST_IDLE;
        next_mem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= compact_load_store_pkg::ST_IDLE;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_size <= compact_load_store_pkg::SIZE_WORD;
      mem_addr <= `CLS_RESET_WORD;
      mem_wdata <= `CLS_RESET_WORD;
      load_signed <= 1'b0;
      rd_sel <= `CLS_RESET_REG;
      rd_we <= 1'b0;
      rd_data <= `CLS_RESET_WORD;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      mem_req <= next_mem_req;
      mem_write <= next_mem_write;
      mem_size <= next_mem_size;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      load_signed <= next_load_signed;
      rd_sel <= next_rd_sel;
      rd_we <= next_rd_we;
      rd_data <= next_rd_data;
      illegal <= next_illegal;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign instr_ready_out = state == compact_load_store_pkg::ST_IDLE;
  assign mem_req_out = mem_req;
  assign mem_write_out = mem_write;
  assign mem_size_out = mem_size;
  assign mem_addr_out = mem_addr;
  assign mem_wdata_out = mem_wdata;
  assign rd_we_out = rd_we;
  assign rd_sel_out = rd_sel;
  assign rd_data_out = rd_data;
  assign illegal_out = illegal;

endmodule

// ### tb/mem_partner_model.sv
// memory side model: random wait of 0 to 3 cycles, scrambled read data
module mem_partner_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  output logic done_out,
  output logic [31:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  int lim;
  logic [31:0] salt;
  logic [31:0] word;
  always @(posedge clk_in) begin
    if (rst_in || !req_in || done_out) begin
      cnt <= 0;
      lim <= $urandom % 4;
      salt <= $urandom;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign word = {addr_in[15:0], ~addr_in[15:0]} ^ salt;
  assign done_out = req_in && (cnt == lim);
  // data is only valid with done, otherwise shows the inverse
  assign rdata_out = done_out ? word : ~word;
endmodule

// ### tb/compact_load_store_sva.sv
// assertions on the ports of the compressed load/store decoder
`include "compact_load_store_defines.svh"
module compact_load_store_sva (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [31:0] instr_addr_in,
  input wire logic instr_ready_out,
  input wire logic [31:0] base_value_in,
  input wire logic [31:0] offset_value_in,
  input wire logic [31:0] src_value_in,
  input wire logic mem_req_out,
  input wire logic mem_write_out,
  input wire compact_load_store_pkg::access_size_t mem_size_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic mem_done_in,
  input wire logic rd_we_out,
  input wire logic [31:0] rd_data_out,
  input wire logic illegal_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] q_i;
  logic [31:0] q_pc, q_b, q_o, q_s;
  wire take = instr_valid_in && instr_ready_out;
  wire pcrel = instr_in[15:11] == `CLS_PCREL_OP;
  wire regoff = instr_in[15:12] == `CLS_REGOFF_OP;
  wire immoff = instr_in[15:13] == `CLS_IMMOFF_OP;
  wire f8 = q_i[15:12] == `CLS_REGOFF_OP && q_i[9];
  always_ff @(posedge clk_in) begin
    if (take) begin
      q_i <= instr_in;
      q_pc <= instr_addr_in;
      q_b <= base_value_in;
      q_o <= offset_value_in;
      q_s <= src_value_in;
    end
  end
  chk_pcrel_word: assert property (take && pcrel |=> mem_req_out &&
    !mem_write_out && mem_addr_out == ((q_pc + 32'h4) & ~32'h2) +
    {22'h0, q_i[7:0], 2'h0}) else $error("pc relative load wrong");
  chk_regoff_addr: assert property (take && regoff |=>
    mem_addr_out == q_b + q_o) else $error("register offset address wrong");
  chk_regoff_dir: assert property (take && regoff && !instr_in[9] |=>
    mem_write_out == !q_i[11] && mem_size_out == (q_i[10] ?
    compact_load_store_pkg::SIZE_BYTE : compact_load_store_pkg::SIZE_WORD))
    else $error("register offset direction or size wrong");
  chk_byte_store: assert property (mem_req_out && mem_write_out &&
    mem_size_out == compact_load_store_pkg::SIZE_BYTE |->
    mem_wdata_out == {24'h0, q_s[7:0]}) else $error("byte store data wrong");
  chk_half_store: assert property (mem_req_out && mem_write_out &&
    mem_size_out == compact_load_store_pkg::SIZE_HALF |->
    mem_wdata_out == {16'h0, q_s[15:0]}) else $error("half store data wrong");
  chk_zero_byte: assert property (rd_we_out && !f8 &&
    mem_size_out == compact_load_store_pkg::SIZE_BYTE
    |-> rd_data_out[31:8] == 24'h0) else $error("byte load not zeroed");
  chk_imm_addr: assert property (take && immoff |=>
    mem_write_out == !q_i[11] && mem_addr_out == q_b + (q_i[12] ?
    {27'h0, q_i[10:6]} : {25'h0, q_i[10:6], 2'h0}))
    else $error("immediate offset access wrong");
  chk_zero_half: assert property (rd_we_out && f8 && q_i[11] && !q_i[10]
    |-> rd_data_out[31:16] == 16'h0) else $error("half load not zeroed");
  chk_sign_byte: assert property (rd_we_out && f8 && !q_i[11] && q_i[10]
    |-> rd_data_out[31:8] == {24{rd_data_out[7]}}) else $error("byte sign");
  chk_sign_half: assert property (rd_we_out && f8 && q_i[11] && q_i[10]
    |-> rd_data_out[31:16] == {16{rd_data_out[15]}}) else $error("half sign");
  chk_done_resp: assert property (mem_req_out && mem_done_in |=>
    !mem_req_out && instr_ready_out && rd_we_out == !$past(mem_write_out))
    else $error("completion response wrong");
  chk_illegal_op: assert property (take && !pcrel && !regoff && !immoff
    |=> illegal_out && !mem_req_out) else $error("illegal not flagged");
endmodule
bind compact_load_store_decode compact_load_store_sva u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
  .instr_in(instr_in), .instr_addr_in(instr_addr_in),
  .instr_ready_out(instr_ready_out), .base_value_in(base_value_in),
  .offset_value_in(offset_value_in), .src_value_in(src_value_in),
  .mem_req_out(mem_req_out), .mem_write_out(mem_write_out),
  .mem_size_out(mem_size_out), .mem_addr_out(mem_addr_out),
  .mem_wdata_out(mem_wdata_out), .mem_done_in(mem_done_in),
  .rd_we_out(rd_we_out), .rd_data_out(rd_data_out),
  .illegal_out(illegal_out));

// ### tb/test_compact_load_store_decode.sv
// self-checking bench for the compressed load/store decoder
module test_compact_load_store_decode;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_in, instr_valid_in, instr_ready_out, mem_req_out;
  logic mem_write_out, mem_done_in, rd_we_out, illegal_out;
  logic [15:0] instr_in, ins;
  logic [2:0] base_sel_out, offset_sel_out, src_sel_out, rd_sel_out;
  logic [31:0] instr_addr_in, mem_addr_out, mem_wdata_out, mem_rdata_in;
  logic [31:0] rd_data_out, e_addr, e_size, e_wd, e_rd, raw;
  logic [31:0] regs [8];
  compact_load_store_pkg::access_size_t mem_size_out;
  int n_fail, total_checks, e_kind, e_ill, k;
  compact_load_store_decode u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .instr_addr_in(instr_addr_in), .instr_ready_out(instr_ready_out),
    .base_sel_out(base_sel_out), .offset_sel_out(offset_sel_out),
    .src_sel_out(src_sel_out), .base_value_in(regs[base_sel_out]),
    .offset_value_in(regs[offset_sel_out]),
    .src_value_in(regs[src_sel_out]), .mem_req_out(mem_req_out),
    .mem_write_out(mem_write_out), .mem_size_out(mem_size_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_done_in(mem_done_in), .mem_rdata_in(mem_rdata_in),
    .rd_we_out(rd_we_out), .rd_sel_out(rd_sel_out),
    .rd_data_out(rd_data_out), .illegal_out(illegal_out));
  mem_partner_model u_mem (.clk_in(clk_in), .rst_in(rst_in),
    .req_in(mem_req_out), .addr_in(mem_addr_out),
    .done_out(mem_done_in), .rdata_out(mem_rdata_in));
  always #10 clk_in = ~clk_in;
  task check(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h got %h", what, exp, got);
    end
  endtask
  task stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task set_ls(input logic ld, byt, input logic [31:0] src);
    e_size = byt ? 32'h0 : 32'h2;
    e_kind = ld ? (byt ? 2 : 1) : 0;
    e_wd = ld ? 32'h0 : (byt ? src & 32'hFF : src);
  endtask
  task model(input logic [15:0] i, input logic [31:0] pc);
    logic [31:0] b;
    b = regs[i[5:3]];
    e_ill = 0; e_rd = {29'h0, i[2:0]}; e_wd = 32'h0; e_kind = 1; e_size = 2;
    if (i[15:11] == 5'h09) begin
      e_addr = ((pc + 32'h4) & ~32'h2) + {22'h0, i[7:0], 2'h0};
      e_rd = {29'h0, i[10:8]};
    end else if (i[15:12] == 4'h5) begin
      e_addr = b + regs[i[8:6]];
      if (!i[9]) set_ls(i[11], i[10], regs[i[2:0]]);
      else case ({i[11], i[10]})
        2'h0: begin e_size = 1; e_kind = 0; e_wd = regs[i[2:0]] & 32'hFFFF; end
        2'h2: begin e_size = 1; e_kind = 3; end
        2'h1: begin e_size = 0; e_kind = 4; end
        default: begin e_size = 1; e_kind = 5; end
      endcase
    end else if (i[15:13] == 3'h3) begin
      e_addr = b + (i[12] ? {27'h0, i[10:6]} : {25'h0, i[10:6], 2'h0});
      set_ls(i[11], i[12], regs[i[2:0]]);
    end else e_ill = 1;
  endtask
  function automatic logic [31:0] ext(input int kd, input logic [31:0] r);
    case (kd)
      2: return {24'h0, r[7:0]};
      3: return {16'h0, r[15:0]};
      4: return {{24{r[7]}}, r[7:0]};
      5: return {{16{r[15]}}, r[15:0]};
      default: return r;
    endcase
  endfunction
  task run(input logic [15:0] i, input logic [31:0] pc);
    foreach (regs[j]) regs[j] = $urandom;
    model(i, pc);
    instr_in = i; instr_addr_in = pc; instr_valid_in = 1'b1;
    @(posedge clk_in); #1 instr_valid_in = 1'b0;
    if (e_ill) begin
      check("illegal", 32'h1, {31'h0, illegal_out});
      check("req", 32'h0, {31'h0, mem_req_out});
      @(posedge clk_in);
      #1;
      check("illegal end", 32'h0, {31'h0, illegal_out});
    end else begin
      check("addr", e_addr, mem_addr_out);
      check("size", e_size, {30'h0, mem_size_out});
      check("write", {31'h0, e_kind == 0}, {31'h0, mem_write_out});
      check("wdata", e_wd, mem_wdata_out);
      k = 0;
      while (mem_done_in !== 1'b1 && k < 20) begin
        @(posedge clk_in); #1 k++;
      end
      check("done", 32'h1, {31'h0, mem_done_in});
      raw = mem_rdata_in;
      @(posedge clk_in); #1;
      check("rd_we", {31'h0, e_kind != 0}, {31'h0, rd_we_out});
      check("ready", 32'h1, {31'h0, instr_ready_out});
      if (e_kind != 0) begin
        check("rd_sel", e_rd, {29'h0, rd_sel_out});
        check("rd_data", ext(e_kind, raw), rd_data_out);
      end
    end
  endtask
  initial begin
    clk_in = 1'b0; rst_in = 1'b1; instr_valid_in = 1'b0;
    instr_in = 16'h0; instr_addr_in = 32'h0;
    foreach (regs[j]) regs[j] = 32'h0;
    void'($urandom(47));
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    check("reset size", 32'h2, {30'h0, mem_size_out});
    check("reset ready", 32'h1, {31'h0, instr_ready_out});
    run(16'h4BFF, 32'h0000_1002);
    run(16'h4800, 32'h0000_0FFE);
    for (int n = 0; n < 200; n++) begin
      ins = $urandom;
      case ($urandom % 4)
        0: ins[15:11] = 5'h09;
        1: ins[15:12] = 4'h5;
        2: ins[15:13] = 3'h3;
        default: ins[15:13] = 3'h0;
      endcase
      run(ins, $urandom & 32'hFFFF_FFFE);
    end
    stop_test;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
endmodule
